/* File: shared/fccd_pkg.sv */
package fccd_pkg;

  // Register word offsets (byte addresses on the slave port)
  localparam logic [3:0] FCCD_OFS_CONFIG = 4'h0;
  localparam logic [3:0] FCCD_OFS_CLKDIV = 4'h4;
  localparam logic [3:0] FCCD_OFS_IRQ_STATUS = 4'h8;

  // Module configuration register fields
  localparam int FCCD_CFG_LOCK_BIT = 10;
  localparam int FCCD_CFG_PV_EN_BIT = 9;
  localparam int FCCD_CFG_AE_EN_BIT = 8;
  localparam int FCCD_CFG_CBE_EN_BIT = 7;
  localparam int FCCD_CFG_CC_EN_BIT = 6;
  localparam int FCCD_CFG_KEY_SEL_BIT = 5;
  localparam logic [15:0] FCCD_CFG_IMPL_MASK = 16'h07e0;
  localparam logic [15:0] FCCD_CFG_RESET = 16'h0000;

  // Clock divider register fields
  localparam int FCCD_CLK_LOADED_BIT = 7;
  localparam int FCCD_CLK_PRESCALE_BIT = 6;
  localparam int FCCD_DIV_WIDTH = 6;
  localparam logic [7:0] FCCD_CLKDIV_RESET = 8'h00;

  // Interrupt status layout, same order as the enables
  localparam int FCCD_IRQ_CC_BIT = 0;
  localparam int FCCD_IRQ_CBE_BIT = 1;
  localparam int FCCD_IRQ_AE_BIT = 2;
  localparam int FCCD_IRQ_PV_BIT = 3;
  localparam logic [3:0] FCCD_IRQ_RESET = 4'h0;

  // Timing figures
  localparam int FCCD_PRESCALE_DIV = 8;
  localparam int FCCD_CLK_PERIOD_NS = 5;
  localparam int FCCD_TEVT_MIN_KHZ = 150;
  localparam int FCCD_TEVT_MAX_KHZ = 200;
  localparam int FCCD_BUSCLK_MIN_KHZ = 150;
  localparam int FCCD_BUSCLK_MAX_KHZ = 102400;

  // Status flags from the command engine, one level each
  typedef struct packed {
    logic prot_violation_flag;
    logic access_error_flag;
    logic cmd_buffer_empty_flag;
    logic cmd_complete_flag;
  } fccd_flags_t;

  // Avalon-MM request as seen by the slave
  typedef struct packed {
    logic [3:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } fccd_avreq_t;

endpackage

/* File: rtl/fccd_prescale.sv */
`timescale 1ns/1ps
module fccd_prescale
  import fccd_pkg::*;
#(
  parameter int RATIO = FCCD_PRESCALE_DIV
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic run_i,
  // One-cycle enable every RATIO clocks
  output logic step_o
);

  logic [$clog2(RATIO)-1:0] count;
  logic last;

  assign last = (count == ($clog2(RATIO))'(RATIO - 1));

  // Free count while running; restart from zero when stopped
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count <= '0;
      step_o <= 1'b0;
    end else begin
      count <= (run_i && !last) ? count + 1'b1 : '0;
      step_o <= run_i && last;
    end
  end

endmodule

/* File: rtl/fccd_tick_div.sv */
`timescale 1ns/1ps
module fccd_tick_div
  import fccd_pkg::*;
#(
  parameter int WIDTH = FCCD_DIV_WIDTH
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic run_i,
  input wire logic step_i,
  input wire logic [WIDTH-1:0] div_i,
  // Wrap pulse, one cycle
  output logic tick_o
);

  logic [WIDTH-1:0] count;
  logic wrap;

  // Divide field plus one steps per period
  assign wrap = step_i && (count == div_i);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count <= '0;
      tick_o <= 1'b0;
    end else if (!run_i) begin
      count <= '0;
      tick_o <= 1'b0;
    end else begin
      if (step_i) begin
        count <= wrap ? '0 : count + 1'b1;
      end
      tick_o <= wrap;
    end
  end

endmodule

/* File: rtl/fccd_top.sv */
// Function
// - Write-lock bit 10 always reads back and, once set, stays set.
// - Lock set blocks writes to protection and access registers.
// - Protection-violation enable bit 9 with flag set requests interrupt.
// - Access-error enable bit 8 with flag set requests interrupt.
// - Command-buffer-empty enable bit 7 with flag set requests interrupt.
// - Command-complete enable bit 6 with flag set requests interrupt.
// - The four interrupt enables are freely readable and writable.
// - Key-access selector bit 5 writable only while backdoor key enabled.
// - Selector zero routes flash writes to commands, one to keys.
// - Config bits 10 to 5 implemented; others read zero, ignore writes.
// - Divider bits 6 to 0 take first write only; bit 7 read-only.
// - Divider-loaded bit clears at reset, sets on write, stays set.
// - Prescale select divides bus clock by eight before the divider.
// - Divide field with prescaler yields a 150-200 KHz timing clock.
// - Divider serves bus clocks from 150 KHz to 102.4 MHz.
// - Backdoor key enable input reads one when key access enabled.
//
// Design decisions made here: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
module fccd_top
  import fccd_pkg::*;
(
  // Clock and reset
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  // Avalon-MM slave
  input wire logic [3:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  // Security and status inputs from the rest of the controller
  input wire logic BACKDOOR_KEY_ENABLE_I,
  input wire fccd_flags_t FLAGS_I,
  // Flash array write routing
  input wire logic FLASH_WRITE_I,
  output logic CMD_WRITE_START_O,
  output logic KEY_WRITE_O,
  output logic KEY_ACCESS_SELECT_O,
  // Lock towards protection and access registers
  output logic PROT_REGS_LOCKED_O,
  // Timing clock and interrupt
  output logic DIVIDER_LOADED_O,
  output logic TIMED_TICK_O,
  output logic IRQ_O
);

  // Byte enables widened to a per-bit write mask
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // Gather a request into the package carrier, unregistered
  fccd_avreq_t req;
  assign req.address = AVS_ADDRESS_I;
  assign req.read = AVS_READ_I;
  assign req.write = AVS_WRITE_I;
  assign req.writedata = AVS_WRITEDATA_I;
  assign req.byteenable = AVS_BYTEENABLE_I;

  // Bus handshake state
  logic waitreq;
  logic next_waitreq;
  logic [31:0] rdata;
  logic [31:0] next_rdata;

  // Configuration register bits
  logic lock;
  logic pv_en;
  logic ae_en;
  logic cbe_en;
  logic cc_en;
  logic key_sel;
  logic next_lock;
  logic next_pv_en;
  logic next_ae_en;
  logic next_cbe_en;
  logic next_cc_en;
  logic next_key_sel;

  // Clock divider register bits
  logic loaded;
  logic prescale;
  logic [FCCD_DIV_WIDTH-1:0] div;
  logic next_loaded;
  logic next_prescale;
  logic [FCCD_DIV_WIDTH-1:0] next_div;

  // Interrupt status
  logic [3:0] irq_stat;
  logic [3:0] next_irq_stat;
  logic [3:0] irq_en;
  logic [3:0] flag_vec;
  logic next_irq;

  // Request is committed on the edge where waitrequest is seen low
  logic req_any;
  logic commit;
  logic wr_commit;
  logic rd_commit;
  logic sel_cfg;
  logic sel_clk;
  logic sel_irq;
  logic [31:0] wmask;
  logic [31:0] wbits;
  logic cfg_wr;
  logic clk_wr;

  assign req_any = req.read || req.write;
  assign commit = req_any && !waitreq;
  assign wr_commit = commit && req.write;
  assign rd_commit = commit && req.read;
  assign sel_cfg = (req.address == FCCD_OFS_CONFIG);
  assign sel_clk = (req.address == FCCD_OFS_CLKDIV);
  assign sel_irq = (req.address == FCCD_OFS_IRQ_STATUS);
  assign wmask = lane_mask(req.byteenable);
  assign wbits = req.writedata & wmask;
  assign cfg_wr = wr_commit && sel_cfg;
  assign clk_wr = wr_commit && sel_clk && req.byteenable[0];

  // One wait cycle per access: waitrequest drops for exactly one edge
  assign next_waitreq = !(req_any && waitreq);

  // Readback images; unimplemented bits are constant zero
  logic [15:0] cfg_image;
  logic [7:0] clk_image;

  assign cfg_image = {5'h00, lock, pv_en, ae_en, cbe_en, cc_en,
                      key_sel, 5'h00} & FCCD_CFG_IMPL_MASK;
  assign clk_image = {loaded, prescale, div};

  // Read data is prepared during the wait cycle, held otherwise.
  // Status shows flags arriving in the wait cycle too, or the clear at
  // the commit edge would drop them unseen.
  assign next_rdata = (req.read && waitreq) ?
                      (sel_cfg ? {16'h0000, cfg_image} :
                       sel_clk ? {24'h000000, clk_image} :
                       sel_irq ? {28'h0000000, next_irq_stat} :
                       32'h00000000) : rdata;

  // Lock only ever goes from zero to one
  assign next_lock = lock ||
                     (cfg_wr && wbits[FCCD_CFG_LOCK_BIT]);

  // Enables follow writes whatever the lock state
  assign next_pv_en = (cfg_wr && wmask[FCCD_CFG_PV_EN_BIT]) ?
                      req.writedata[FCCD_CFG_PV_EN_BIT] : pv_en;
  assign next_ae_en = (cfg_wr && wmask[FCCD_CFG_AE_EN_BIT]) ?
                      req.writedata[FCCD_CFG_AE_EN_BIT] : ae_en;
  assign next_cbe_en = (cfg_wr && wmask[FCCD_CFG_CBE_EN_BIT]) ?
                       req.writedata[FCCD_CFG_CBE_EN_BIT] : cbe_en;
  assign next_cc_en = (cfg_wr && wmask[FCCD_CFG_CC_EN_BIT]) ?
                      req.writedata[FCCD_CFG_CC_EN_BIT] : cc_en;

  // Selector accepts writes only while backdoor key access is enabled
  assign next_key_sel = (cfg_wr && wmask[FCCD_CFG_KEY_SEL_BIT] &&
                         BACKDOOR_KEY_ENABLE_I) ?
                        req.writedata[FCCD_CFG_KEY_SEL_BIT] : key_sel;

  // Divider fields take the first write after reset, then freeze
  assign next_prescale = (clk_wr && !loaded) ?
                         req.writedata[FCCD_CLK_PRESCALE_BIT] :
                         prescale;
  assign next_div = (clk_wr && !loaded) ?
                    req.writedata[FCCD_DIV_WIDTH-1:0] : div;
  assign next_loaded = loaded || clk_wr;

  // Sticky status: a flag seen in the clearing cycle survives the clear
  assign flag_vec = {FLAGS_I.prot_violation_flag,
                     FLAGS_I.access_error_flag,
                     FLAGS_I.cmd_buffer_empty_flag,
                     FLAGS_I.cmd_complete_flag};
  assign next_irq_stat = ((rd_commit && sel_irq) ? 4'h0 : irq_stat) |
                         flag_vec;

  // Mask as it stands after this edge, so an enable write acts at once
  assign irq_en = {next_pv_en, next_ae_en,
                   next_cbe_en, next_cc_en};
  assign next_irq = |(irq_en & next_irq_stat);

  // Bus slave flops
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      waitreq <= 1'b1;
      rdata <= 32'h00000000;
    end else begin
      waitreq <= next_waitreq;
      rdata <= next_rdata;
    end
  end

  assign AVS_WAITREQUEST_O = waitreq;
  assign AVS_READDATA_O = rdata;

  // Configuration flops; reset clears every control bit
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      lock <= FCCD_CFG_RESET[FCCD_CFG_LOCK_BIT];
      pv_en <= FCCD_CFG_RESET[FCCD_CFG_PV_EN_BIT];
      ae_en <= FCCD_CFG_RESET[FCCD_CFG_AE_EN_BIT];
      cbe_en <= FCCD_CFG_RESET[FCCD_CFG_CBE_EN_BIT];
      cc_en <= FCCD_CFG_RESET[FCCD_CFG_CC_EN_BIT];
      key_sel <= FCCD_CFG_RESET[FCCD_CFG_KEY_SEL_BIT];
    end else begin
      lock <= next_lock;
      pv_en <= next_pv_en;
      ae_en <= next_ae_en;
      cbe_en <= next_cbe_en;
      cc_en <= next_cc_en;
      key_sel <= next_key_sel;
    end
  end

  // Divider flops; clearing loaded rearms the one-time write
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      loaded <= FCCD_CLKDIV_RESET[FCCD_CLK_LOADED_BIT];
      prescale <= FCCD_CLKDIV_RESET[FCCD_CLK_PRESCALE_BIT];
      div <= FCCD_CLKDIV_RESET[FCCD_DIV_WIDTH-1:0];
    end else begin
      loaded <= next_loaded;
      prescale <= next_prescale;
      div <= next_div;
    end
  end

  // Interrupt flops
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      irq_stat <= FCCD_IRQ_RESET;
      IRQ_O <= 1'b0;
    end else begin
      irq_stat <= next_irq_stat;
      IRQ_O <= next_irq;
    end
  end

  // Status outputs, each a registered copy of its register bit
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      PROT_REGS_LOCKED_O <= 1'b0;
      KEY_ACCESS_SELECT_O <= 1'b0;
      DIVIDER_LOADED_O <= 1'b0;
    end else begin
      PROT_REGS_LOCKED_O <= next_lock;
      KEY_ACCESS_SELECT_O <= next_key_sel;
      DIVIDER_LOADED_O <= next_loaded;
    end
  end

  // Flash array writes go to the command path or the key path
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      CMD_WRITE_START_O <= 1'b0;
      KEY_WRITE_O <= 1'b0;
    end else begin
      CMD_WRITE_START_O <= FLASH_WRITE_I && !key_sel;
      KEY_WRITE_O <= FLASH_WRITE_I && key_sel;
    end
  end

  // Timing clock runs only once software has loaded the divider,
  // so no program or erase timing starts from an unset divide.
  logic pre_step;
  logic div_step;
  logic tick;

  fccd_prescale #(
    .RATIO(FCCD_PRESCALE_DIV)
  ) u_prescale (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .run_i(loaded && prescale),
    .step_o(pre_step)
  );

  // Prescaler bypassed: every bus clock advances the divider
  assign div_step = prescale ? pre_step : 1'b1;

  // Wrap after divide field plus one steps; the counters hold any
  // divide from one to 64 steps, covering the whole bus clock range.
  fccd_tick_div #(
    .WIDTH(FCCD_DIV_WIDTH)
  ) u_tick_div (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .run_i(loaded),
    .step_i(div_step),
    .div_i(div),
    .tick_o(tick)
  );

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      TIMED_TICK_O <= 1'b0;
    end else begin
      TIMED_TICK_O <= tick;
    end
  end

endmodule

/* File: test/fccd_top_asserts.sv */
`timescale 1ns/1ps
module fccd_checker
  import fccd_pkg::*;
(
  // Clock and reset
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  // Register bus
  input wire logic [3:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  input wire logic [31:0] AVS_READDATA_O,
  input wire logic AVS_WAITREQUEST_O,
  // Controller side
  input wire logic BACKDOOR_KEY_ENABLE_I,
  input wire fccd_flags_t FLAGS_I,
  input wire logic FLASH_WRITE_I,
  input wire logic CMD_WRITE_START_O,
  input wire logic KEY_WRITE_O,
  input wire logic KEY_ACCESS_SELECT_O,
  input wire logic PROT_REGS_LOCKED_O,
  input wire logic DIVIDER_LOADED_O,
  input wire logic TIMED_TICK_O,
  input wire logic IRQ_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);

  // Read data stand only at the edge where waitrequest is low
  wire ack = !AVS_WAITREQUEST_O;
  wire cfg_rd = AVS_READ_I && ack && AVS_ADDRESS_I == FCCD_OFS_CONFIG;
  wire div_rd = AVS_READ_I && ack && AVS_ADDRESS_I == FCCD_OFS_CLKDIV;
  wire any_flag = FLAGS_I != 4'h0;

  lock_sticky_a:
    assert property (PROT_REGS_LOCKED_O |=> PROT_REGS_LOCKED_O)
    else $error("lock output cleared without reset");
  loaded_sticky_a:
    assert property (DIVIDER_LOADED_O |=> DIVIDER_LOADED_O)
    else $error("divider loaded flag cleared without reset");
  cfg_reserved_a:
    assert property (cfg_rd |-> (AVS_READDATA_O & 32'hffff_f81f) == 32'h0)
    else $error("config read shows bits outside 10 to 5");
  lock_readback_a:
    assert property (cfg_rd |-> AVS_READDATA_O[10] == PROT_REGS_LOCKED_O)
    else $error("config read lock bit differs from lock output");
  div_readback_a:
    assert property (div_rd |-> AVS_READDATA_O[31:8] == 24'h0 &&
      AVS_READDATA_O[7] == DIVIDER_LOADED_O)
    else $error("divider read shows wrong upper or loaded bit");
  cmd_route_a:
    assert property (FLASH_WRITE_I && !KEY_ACCESS_SELECT_O |=>
      CMD_WRITE_START_O && !KEY_WRITE_O)
    else $error("flash write not routed to commands");
  key_route_a:
    assert property (FLASH_WRITE_I && KEY_ACCESS_SELECT_O |=>
      KEY_WRITE_O && !CMD_WRITE_START_O)
    else $error("flash write not routed to keys");
  key_guard_a:
    assert property ($changed(KEY_ACCESS_SELECT_O) |->
      $past(BACKDOOR_KEY_ENABLE_I))
    else $error("selector changed while key access disabled");
  wait_pulse_a:
    assert property (ack |=> AVS_WAITREQUEST_O)
    else $error("waitrequest low for more than one cycle");
  irq_cause_a:
    assert property ($rose(IRQ_O) |-> $past(any_flag) ||
      $past(any_flag, 2) || $past(AVS_WRITE_I, 2) || $past(AVS_WRITE_I, 3))
    else $error("interrupt rose with no flag or enable write");

  // Main scenarios reached
  cover property ($rose(IRQ_O));
  cover property (KEY_WRITE_O);
  cover property ($rose(PROT_REGS_LOCKED_O));
endmodule

bind fccd_top fccd_checker i_fccd_checker (
  .CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
  .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
  .AVS_WRITEDATA_I(AVS_WRITEDATA_I), .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I),
  .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
  .BACKDOOR_KEY_ENABLE_I(BACKDOOR_KEY_ENABLE_I), .FLAGS_I(FLAGS_I),
  .FLASH_WRITE_I(FLASH_WRITE_I), .CMD_WRITE_START_O(CMD_WRITE_START_O),
  .KEY_WRITE_O(KEY_WRITE_O), .KEY_ACCESS_SELECT_O(KEY_ACCESS_SELECT_O),
  .PROT_REGS_LOCKED_O(PROT_REGS_LOCKED_O),
  .DIVIDER_LOADED_O(DIVIDER_LOADED_O), .TIMED_TICK_O(TIMED_TICK_O),
  .IRQ_O(IRQ_O)
);

/* File: test/fccd_host.sv */
`timescale 1ns/1ps
module fccd_host
  import fccd_pkg::*;
(
  // Clock and answer
  input wire logic clk_i,
  input wire logic wait_i,
  input wire logic [31:0] rdata_i,
  // Request
  output fccd_avreq_t req_o
);
  initial req_o = '0;

  // One access; request held until waitrequest is sampled low.
  // No own limit: a hung slave is caught by the bench watchdog.
  task automatic acc(input logic [3:0] a, input logic w,
    input logic [31:0] d, input logic [3:0] be, output logic [31:0] q);
    @(posedge clk_i);
    req_o <= '{a, !w, w, d, be};
    do @(posedge clk_i); while (wait_i !== 1'b0);
    q = rdata_i;
    req_o <= '0;
  endtask
endmodule

/* File: test/tb_flash_ctrl_config_and_clock_divider.sv */
`timescale 1ns/1ps
module tb_flash_ctrl_config_and_clock_divider;
  import fccd_pkg::*;
  logic clk, rst, bke, fw;
  fccd_flags_t flags;
  fccd_avreq_t req;
  logic [31:0] rdata, q;
  logic waitr, cmd, key, ksel, lckd, ldd, tick, irq;
  int n_fail = 0;
  int checked = 0;
  int seed = 67;
  // Register model
  int cfg, clkd;

  fccd_top i_fccd_top (
    .CLK_I(clk), .SYS_RST_I(rst), .AVS_ADDRESS_I(req.address),
    .AVS_READ_I(req.read), .AVS_WRITE_I(req.write),
    .AVS_WRITEDATA_I(req.writedata), .AVS_BYTEENABLE_I(req.byteenable),
    .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitr),
    .BACKDOOR_KEY_ENABLE_I(bke), .FLAGS_I(flags), .FLASH_WRITE_I(fw),
    .CMD_WRITE_START_O(cmd), .KEY_WRITE_O(key), .KEY_ACCESS_SELECT_O(ksel),
    .PROT_REGS_LOCKED_O(lckd), .DIVIDER_LOADED_O(ldd),
    .TIMED_TICK_O(tick), .IRQ_O(irq)
  );
  fccd_host i_fccd_host (
    .clk_i(clk), .wait_i(waitr), .rdata_i(rdata), .req_o(req)
  );

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Write, then update the model; key enable is held over the access
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    int m;
    i_fccd_host.acc(a, 1'b1, v, 4'hf, q);
    m = bke ? 32'h3e0 : 32'h3c0;
    if (a == FCCD_OFS_CONFIG) cfg = (cfg & ~m) | (v & (m | 32'h400));
    if (a == FCCD_OFS_CLKDIV && clkd < 32'h80) clkd = (v & 32'h7f) | 32'h80;
  endtask

  task automatic rd(input logic [3:0] a, input int e);
    i_fccd_host.acc(a, 1'b0, 32'h0, 4'hf, q);
    chk(q, e);
  endtask

  // Cycles from one tick to the next
  task automatic per(input int e);
    int n;
    n = 0;
    do @(posedge clk); while (tick !== 1'b1);
    do begin
      @(posedge clk);
      n++;
    end while (tick !== 1'b1 && n < 500);
    chk(n, e);
  endtask

  // One-cycle flag pulse, then wait until the interrupt has settled
  task automatic pulse(input fccd_flags_t f);
    flags <= f;
    @(posedge clk);
    flags <= '0;
    repeat (2) @(posedge clk);
  endtask

  task automatic end_sim();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Watchdog, far beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    end_sim();
  end

  initial begin
    rst = 1'b1; bke = 1'b0; fw = 1'b0; flags = '0; cfg = 0; clkd = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(FCCD_OFS_CONFIG, 0);
    rd(FCCD_OFS_CLKDIV, 0);
    rd(FCCD_OFS_IRQ_STATUS, 0);
    rd(4'hc, 0);
    // Random enables and selector under both key states, lock kept clear
    repeat (8) begin
      bke <= 1'($random(seed));
      wr(FCCD_OFS_CONFIG, $random(seed) & 32'hffff_fbff);
      rd(FCCD_OFS_CONFIG, cfg);
      chk(ksel, cfg[5]);
    end
    // Flash writes follow the selector
    bke <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      wr(FCCD_OFS_CONFIG, k << 5);
      fw <= 1'b1;
      @(posedge clk);
      fw <= 1'b0;
      @(posedge clk);
      chk({cmd, key}, k ? 2'b01 : 2'b10);
    end
    // Each flag tried against its own enable and against the others
    for (int i = 0; i < 4; i++) begin
      wr(FCCD_OFS_CONFIG, 32'h40 << i);
      pulse(~(4'h1 << i));
      chk(irq, 0);
      rd(FCCD_OFS_IRQ_STATUS, ~(32'h1 << i) & 32'hf);
      pulse(4'h1 << i);
      chk(irq, 1);
      rd(FCCD_OFS_IRQ_STATUS, 1 << i);
      repeat (2) @(posedge clk);
      chk(irq, 0);
    end
    // Lock sets once and survives a clearing write
    wr(FCCD_OFS_CONFIG, 32'h400);
    wr(FCCD_OFS_CONFIG, 32'h0);
    rd(FCCD_OFS_CONFIG, cfg);
    chk(lckd, 1);
    // Divider loaded before any timed work; second write ignored
    wr(FCCD_OFS_CLKDIV, 32'h43);
    wr(FCCD_OFS_CLKDIV, 32'h05);
    rd(FCCD_OFS_CLKDIV, clkd);
    chk(ldd, 1);
    per(FCCD_PRESCALE_DIV * 4);
    // Mid-run reset rearms the one-time divider write
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    cfg = 0;
    clkd = 0;
    rd(FCCD_OFS_CONFIG, cfg);
    chk(ldd, 0);
    wr(FCCD_OFS_CLKDIV, 32'h02);
    rd(FCCD_OFS_CLKDIV, clkd);
    per(3);
    end_sim();
  end
endmodule
